/* common/apb_multi_down_timer_map.vh */
/*
 * Address map, control field positions, reset values and build defaults
 * of the multi-timer block.
 * Assumes it is included by bare name from the hdl files and holds
 * definitions only.
 */
`ifndef APB_MULTI_DOWN_TIMER_MAP_VH
`define APB_MULTI_DOWN_TIMER_MAP_VH

// Bus geometry
`define TMR_MAX_TIMERS 8
`define TMR_ADDR_W 12
`define TMR_DATA_W 32
`define TMR_STRB_W 4

// Address split: paddr[8] picks global space, paddr[7:5] the timer, paddr[4:0] the register
`define TMR_GLOBAL_BIT 8
`define TMR_IDX_HI 7
`define TMR_IDX_LO 5
`define TMR_OFS_HI 4
`define TMR_UPPER_LO 9
`define TMR_UPPER_W 3
`define TMR_UPPER_ZERO 3'h0

// Per-timer register offsets inside a timer's 32-byte slot
`define TMR_OFS_LOAD 5'h00
`define TMR_OFS_CURRENT 5'h04
`define TMR_OFS_CONTROL 5'h08
`define TMR_OFS_EOI 5'h0c
`define TMR_OFS_STATUS 5'h10

// Global register offsets inside the global space
`define TMR_GOFS_STATUS 8'h00
`define TMR_GOFS_EOI 8'h04
`define TMR_GOFS_RAW 8'h08

// Control register fields
`define TMR_CTRL_W 3
`define TMR_CTRL_EN 0
`define TMR_CTRL_MODE 1
`define TMR_CTRL_MASK 2
`define TMR_CTRL_RST 3'h0

// Reset values
`define TMR_LOAD_RST 32'h0
`define TMR_RDATA_RST 32'h0
`define TMR_COUNT_RST 32'h0
`define TMR_ALL_ONES 32'hffffffff
`define TMR_FULL_W 32

// Build defaults
`define TMR_DEF_NUM 4'h8
`define TMR_DEF_WIDTHS 64'h2020202020202020
`define TMR_WIDTH_FIELD 8

`endif

/* hdl/down_timer_core.v */
/*
 * One down-counting timer: load on first tick after enable, count down on each tick,
 * reload and flag an event on the tick that leaves zero, toggle on every reload.
 * Assumes tick is a one-cycle enable pulse in the clk_sys domain.
 */
`timescale 1ns/100ps
`include "apb_multi_down_timer_map.vh"

module down_timer_core #(
    parameter WIDTH = 32
) (
    input wire clk_sys,
    input wire rst,
    input wire enable,
    input wire tick,
    input wire userMode,
    input wire [31:0] loadVal,
    output wire [31:0] count,
    output wire toggle,
    output wire zeroReload
);
    localparam [31:0] WIDTH_MASK = `TMR_ALL_ONES >> (`TMR_FULL_W - WIDTH);

    reg [31:0] cnt_q;
    reg started_q;
    reg toggle_q;
    reg evt_q;

    always @(posedge clk_sys) begin
        if (rst || !enable) begin
            // Disabled timer: counter and toggle cleared
            cnt_q <= `TMR_COUNT_RST;
            started_q <= 1'b0;
            toggle_q <= 1'b0;
            evt_q <= 1'b0;
        end else begin
            evt_q <= 1'b0;
            if (tick) begin
                if (!started_q) begin
                    cnt_q <= loadVal & WIDTH_MASK;
                    started_q <= 1'b1;
                end else if (cnt_q == `TMR_COUNT_RST) begin
                    if (userMode) begin
                        cnt_q <= loadVal & WIDTH_MASK;
                    end else begin
                        cnt_q <= WIDTH_MASK;
                    end
                    evt_q <= 1'b1;
                    toggle_q <= ~toggle_q;
                end else begin
                    cnt_q <= cnt_q - 32'h1;
                end
            end
        end
    end

    assign count = cnt_q;
    assign toggle = toggle_q;
    assign zeroReload = evt_q;
endmodule // down_timer_core

/* hdl/irq_event_flag.v */
/*
 * Sticky interrupt flag: set by a timer event, cleared by an end-of-interrupt read
 * or by disabling the timer; a set wins over an end-of-interrupt clear in the same cycle, a disable wins over a set.
 * Assumes all inputs are in the clk_sys domain.
 */
`timescale 1ns/100ps

module irq_event_flag (
    input wire clk_sys,
    input wire rst,
    input wire setEvt,
    input wire clearEvt,
    input wire timerOff,
    output wire flag
);
    reg flag_q;

    always @(posedge clk_sys) begin
        if (rst || timerOff) begin
            flag_q <= 1'b0;
        end else if (setEvt) begin
            flag_q <= 1'b1;
        end else if (clearEvt) begin
            flag_q <= 1'b0;
        end
    end

    assign flag = flag_q;
endmodule // irq_event_flag

/* hdl/apb_multi_down_timer.v */
/*
 * Bank of up to eight down-counting timers behind one APB slave port, with
 * per-timer interrupts of selectable polarity, an optional merged interrupt,
 * optional toggle outputs and per-timer clock-request outputs.
 * Assumes the APB master drives clk_sys as its bus clock; each timer clock input
 * is synchronous to clk_sys and is used as a rising-edge count enable, or is
 * replaced by clk_sys itself where TIMER_CLK_IS_SYS has its bit set.
 */
`timescale 1ns/100ps
`include "apb_multi_down_timer_map.vh"

module apb_multi_down_timer #(
    parameter [3:0] NUM_TIMERS = `TMR_DEF_NUM,
    parameter [63:0] TIMER_WIDTHS = `TMR_DEF_WIDTHS,
    parameter [7:0] TIMER_CLK_IS_SYS = 8'hff,
    parameter [7:0] IRQ_ACTIVE_LOW = 8'h00,
    parameter merged_irq_option = 1,
    parameter extended_features_option = 0,
    parameter TOGGLE_OPTION = 1
) (
    input wire clk_sys,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`TMR_ADDR_W-1:0] paddr,
    input wire [`TMR_DATA_W-1:0] pwdata,
    input wire [`TMR_STRB_W-1:0] pstrb,
    output wire [`TMR_DATA_W-1:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [`TMR_MAX_TIMERS-1:0] timerClk,
    output wire [`TMR_MAX_TIMERS-1:0] timerEn,
    output wire [`TMR_MAX_TIMERS-1:0] timerIrq,
    output wire mergedIrq,
    output wire [`TMR_MAX_TIMERS-1:0] timerToggle
);
    // Bus phase decode
    wire setupRead;
    wire accessPhase;
    wire accessWrite;
    wire globalSpace;
    wire upperClear;
    wire [2:0] timerIdx;
    wire [4:0] regOfs;
    wire [7:0] globalOfs;
    wire timerPresent;
    wire globalEoiRead;

    // Per-timer state gathered for the read path
    wire [`TMR_MAX_TIMERS*32-1:0] loadFlat;
    wire [`TMR_MAX_TIMERS*32-1:0] countFlat;
    wire [`TMR_MAX_TIMERS*`TMR_CTRL_W-1:0] ctrlFlat;
    wire [`TMR_MAX_TIMERS-1:0] rawFlag;
    wire [`TMR_MAX_TIMERS-1:0] maskedFlag;
    wire [`TMR_MAX_TIMERS-1:0] toggleVec;

    reg [`TMR_DATA_W-1:0] rdata_q;
    reg [`TMR_DATA_W-1:0] rdata_d;
    reg rdHit;
    reg [`TMR_MAX_TIMERS-1:0] irqOut_q;
    reg merged_q;

    assign setupRead = psel && !penable && !pwrite;
    assign accessPhase = psel && penable;
    assign accessWrite = accessPhase && pwrite;
    assign globalSpace = paddr[`TMR_GLOBAL_BIT];
    assign upperClear = (paddr[`TMR_ADDR_W-1:`TMR_UPPER_LO] == `TMR_UPPER_ZERO);
    assign timerIdx = paddr[`TMR_IDX_HI:`TMR_IDX_LO];
    assign regOfs = paddr[`TMR_OFS_HI:0];
    assign globalOfs = paddr[`TMR_IDX_HI:0];
    assign timerPresent = ({1'b0, timerIdx} < NUM_TIMERS);

    // Clear of every flag happens on the setup edge of the read, as penable is low
    assign globalEoiRead = setupRead && upperClear && globalSpace
        && (globalOfs == `TMR_GOFS_EOI);

    genvar i;
    generate
        for (i = 0; i < `TMR_MAX_TIMERS; i = i + 1) begin : g_timer
            if (i < NUM_TIMERS) begin : g_on
                localparam WIDTH = TIMER_WIDTHS[i*`TMR_WIDTH_FIELD +: `TMR_WIDTH_FIELD];
                localparam [31:0] WIDTH_MASK = `TMR_ALL_ONES >> (`TMR_FULL_W - WIDTH);

                reg [`TMR_CTRL_W-1:0] ctrl_q;
                reg [31:0] load_q;
                reg clkPrev_q;
                wire sel;
                wire tick;
                wire evt;
                wire eoiRead;
                wire [31:0] cnt;
                integer b;

                assign sel = upperClear && !globalSpace && (timerIdx == i);
                assign eoiRead = setupRead && sel && (regOfs == `TMR_OFS_EOI);

                always @(posedge clk_sys) begin
                    if (rst) begin
                        ctrl_q <= `TMR_CTRL_RST;
                        load_q <= `TMR_LOAD_RST;
                    end else if (accessWrite && sel) begin
                        if (regOfs == `TMR_OFS_CONTROL && pstrb[0]) begin
                            ctrl_q <= pwdata[`TMR_CTRL_W-1:0];
                        end
                        if (regOfs == `TMR_OFS_LOAD) begin
                            for (b = 0; b < `TMR_STRB_W; b = b + 1) begin
                                if (pstrb[b]) begin
                                    load_q[b*8 +: 8] <= pwdata[b*8 +: 8];
                                end
                            end
                        end
                    end
                end

                // Timer clock is a rising-edge count enable, or every cycle when tied
                always @(posedge clk_sys) begin
                    if (rst) begin
                        clkPrev_q <= 1'b0;
                    end else begin
                        clkPrev_q <= timerClk[i];
                    end
                end
                assign tick = TIMER_CLK_IS_SYS[i] ? 1'b1 : (timerClk[i] && !clkPrev_q);

                down_timer_core #(
                    .WIDTH(WIDTH)
                ) u_core (
                    .clk_sys(clk_sys),
                    .rst(rst),
                    .enable(ctrl_q[`TMR_CTRL_EN]),
                    .tick(tick),
                    .userMode(ctrl_q[`TMR_CTRL_MODE]),
                    .loadVal(load_q),
                    .count(cnt),
                    .toggle(toggleVec[i]),
                    .zeroReload(evt)
                );

                irq_event_flag u_flag (
                    .clk_sys(clk_sys),
                    .rst(rst),
                    .setEvt(evt),
                    .clearEvt(eoiRead || globalEoiRead),
                    .timerOff(!ctrl_q[`TMR_CTRL_EN]),
                    .flag(rawFlag[i])
                );

                assign loadFlat[i*32 +: 32] = load_q & WIDTH_MASK;
                assign countFlat[i*32 +: 32] = cnt;
                assign ctrlFlat[i*`TMR_CTRL_W +: `TMR_CTRL_W] = ctrl_q;
                assign maskedFlag[i] = rawFlag[i] && !ctrl_q[`TMR_CTRL_MASK];
                assign timerEn[i] = ctrl_q[`TMR_CTRL_EN];
            end else begin : g_off
                assign loadFlat[i*32 +: 32] = `TMR_LOAD_RST;
                assign countFlat[i*32 +: 32] = `TMR_COUNT_RST;
                assign ctrlFlat[i*`TMR_CTRL_W +: `TMR_CTRL_W] = `TMR_CTRL_RST;
                assign rawFlag[i] = 1'b0;
                assign maskedFlag[i] = 1'b0;
                assign toggleVec[i] = 1'b0;
                assign timerEn[i] = 1'b0;
            end
        end
    endgenerate

    // Read path: chosen in setup phase, held in a flop for the access phase
    always @* begin
        rdata_d = `TMR_RDATA_RST;
        rdHit = 1'b0;
        if (upperClear && globalSpace) begin
            case (globalOfs)
                `TMR_GOFS_STATUS: begin
                    rdata_d[`TMR_MAX_TIMERS-1:0] = maskedFlag;
                    rdHit = 1'b1;
                end
                `TMR_GOFS_EOI: begin
                    rdHit = 1'b1;
                end
                `TMR_GOFS_RAW: begin
                    rdata_d[`TMR_MAX_TIMERS-1:0] = rawFlag;
                    rdHit = 1'b1;
                end
                default: begin
                    rdHit = 1'b0;
                end
            endcase
        end else if (upperClear && timerPresent) begin
            case (regOfs)
                `TMR_OFS_LOAD: begin
                    rdata_d = loadFlat[timerIdx*32 +: 32];
                    rdHit = 1'b1;
                end
                `TMR_OFS_CURRENT: begin
                    rdata_d = countFlat[timerIdx*32 +: 32];
                    rdHit = 1'b1;
                end
                `TMR_OFS_CONTROL: begin
                    rdata_d[`TMR_CTRL_W-1:0] = ctrlFlat[timerIdx*`TMR_CTRL_W +: `TMR_CTRL_W];
                    rdHit = 1'b1;
                end
                `TMR_OFS_EOI: begin
                    rdHit = 1'b1;
                end
                `TMR_OFS_STATUS: begin
                    rdata_d[0] = maskedFlag[timerIdx];
                    rdHit = 1'b1;
                end
                default: begin
                    rdHit = 1'b0;
                end
            endcase
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            rdata_q <= `TMR_RDATA_RST;
        end else if (setupRead) begin
            rdata_q <= rdata_d;
        end
    end

    // Single-cycle access phase for every APB generation; error only on unmapped addresses
    assign pready = 1'b1;
    assign pslverr = accessPhase && !rdHit;
    assign prdata = rdata_q;

    // Interrupt outputs, registered; per-timer lines with per-timer polarity, merged line active high
    always @(posedge clk_sys) begin
        if (rst) begin
            irqOut_q <= IRQ_ACTIVE_LOW;
            merged_q <= 1'b0;
        end else begin
            irqOut_q <= maskedFlag ^ IRQ_ACTIVE_LOW;
            merged_q <= (merged_irq_option != 0) && (|maskedFlag);
        end
    end

    assign timerIrq = irqOut_q;
    assign mergedIrq = merged_q;
    assign timerToggle = (TOGGLE_OPTION != 0) ? toggleVec : {`TMR_MAX_TIMERS{1'b0}};
endmodule // apb_multi_down_timer

/* bench/apb_timer_chk.sv */
/*
 * Port checker for the multi-timer block, bound to its top module.
 * Assumes one clock, clk_sys, and a synchronous active-high reset.
 */
`timescale 1ns/100ps

module apb_timer_chk #(
    parameter [7:0] IRQ_ACTIVE_LOW = 8'h00
) (
    input wire clk_sys,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [7:0] timerClk,
    input wire [7:0] timerEn,
    input wire [7:0] timerIrq,
    input wire mergedIrq,
    input wire [7:0] timerToggle
);
    wire ctrlWr = psel && penable && pwrite && paddr[11:8] == 4'h0 && paddr[4:0] == 5'h08
        && pstrb[0];
    wire rdSetup = psel && !penable && !pwrite && paddr[11:9] == 3'h0;
    wire [7:0] irqHigh = timerIrq ^ IRQ_ACTIVE_LOW;
    reg [7:0] enPrev_q;

    always @(posedge clk_sys) begin
        enPrev_q <= timerEn;
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_upper: assert property (psel && penable && paddr[11:9] != 3'h0 |-> pslverr)
        else $error("no error on unmapped address");
    a_en_write: assert property (ctrlWr |=> timerEn[$past(paddr[7:5])] == $past(pwdata[0]))
        else $error("enable output does not follow control write");
    a_en_hold: assert property (!ctrlWr && !$past(rst) |=> $stable(timerEn))
        else $error("enable output moved without control write");
    a_merged_or: assert property (mergedIrq == |irqHigh)
        else $error("merged interrupt differs from OR of interrupts");
    a_eoi_zero: assert property (rdSetup && ((!paddr[8] && paddr[4:0] == 5'h0c)
        || paddr[8:0] == 9'h104) |=> prdata == 32'h0)
        else $error("end-of-interrupt read not zero");
    a_cur_idle: assert property (rdSetup && !paddr[8] && paddr[4:0] == 5'h04
        && !timerEn[paddr[7:5]] && !enPrev_q[paddr[7:5]] |=> prdata == 32'h0)
        else $error("disabled timer shows nonzero count");
    a_dis_drops: assert property ($fell(timerEn[1]) |-> ##[1:3] !irqHigh[1])
        else $error("interrupt kept after disable");
    a_irq_cause: assert property (irqHigh[1] |-> $past(timerEn[1], 2) || $past(timerEn[1], 3))
        else $error("interrupt from disabled timer");
endmodule // apb_timer_chk

bind apb_multi_down_timer apb_timer_chk #(.IRQ_ACTIVE_LOW(IRQ_ACTIVE_LOW)) i_apb_timer_chk (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timerClk(timerClk), .timerEn(timerEn), .timerIrq(timerIrq),
    .mergedIrq(mergedIrq), .timerToggle(timerToggle));

/* bench/apb_master_model.sv */
/*
 * APB master standing in for a bus bridge: one transfer per start pulse.
 * Assumes start is raised only while idle; address and data are inverted on release.
 */
`timescale 1ns/100ps

module apb_master_model (
    input wire clk_sys,
    input wire rst,
    input wire start,
    input wire wr,
    input wire [11:0] addr,
    input wire [31:0] wdata,
    output reg psel = 1'b0,
    output reg penable = 1'b0,
    output reg pwrite = 1'b0,
    output reg [11:0] paddr = 12'h0,
    output reg [31:0] pwdata = 32'h0,
    output wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    output reg done = 1'b0,
    output reg [31:0] rdata = 32'h0,
    output reg err = 1'b0
);
    assign pstrb = 4'hf;

    always @(posedge clk_sys) begin
        done <= 1'b0;
        if (rst) begin
            psel <= 1'b0;
            penable <= 1'b0;
        end else if (psel && penable && pready) begin
            psel <= 1'b0;
            penable <= 1'b0;
            rdata <= prdata;
            err <= pslverr;
            done <= 1'b1;
            paddr <= ~paddr;
            pwdata <= ~pwdata;
        end else if (psel) begin
            penable <= 1'b1;
        end else if (start) begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= addr;
            pwdata <= wdata;
        end
    end
endmodule // apb_master_model

/* bench/tb_top.sv */
/*
 * Self-checking bench for the multi-timer block.
 * Assumes timer 0 counts on its clock input, the others on clk_sys.
 */
`timescale 1ns/100ps

module tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic wr = 1'b0;
    logic [11:0] addr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic [7:0] timerClk = 8'h0;
    wire psel, penable, pwrite, pready, pslverr, done, err, mergedIrq;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata, rdata;
    wire [3:0] pstrb;
    wire [7:0] timerEn, timerIrq, timerToggle;
    int failures = 0;
    int numChecks = 0;
    int n;
    logic [31:0] ld;

    always #12.5 clk_sys = ~clk_sys;

    // Timer 0 clock runs only while its clock request is high
    always @(posedge clk_sys) timerClk <= {7'h0, timerEn[0] & ~timerClk[0]};

    apb_multi_down_timer #(.TIMER_WIDTHS(64'h2020202020200820), .TIMER_CLK_IS_SYS(8'hfe),
        .extended_features_option(0),
        .IRQ_ACTIVE_LOW(8'h80)) i_apb_multi_down_timer (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timerClk(timerClk), .timerEn(timerEn), .timerIrq(timerIrq),
        .mergedIrq(mergedIrq), .timerToggle(timerToggle));

    apb_master_model i_apb_master_model (.clk_sys(clk_sys), .rst(rst), .start(start),
        .wr(wr), .addr(addr), .wdata(wdata), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .done(done), .rdata(rdata), .err(err));

    task results;
        begin
            $display("checks %0d failures %0d", numChecks, failures);
            if (failures == 0 && numChecks > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            numChecks++;
            if (seen !== exp) begin
                failures++;
                $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        begin
            @(posedge clk_sys);
            start <= 1'b1;
            wr <= w;
            addr <= a;
            wdata <= d;
            @(posedge clk_sys);
            start <= 1'b0;
            for (k = 0; k < 8; k++) begin
                @(posedge clk_sys);
                if (done === 1'b1) break;
            end
            if (k == 8) begin
                failures++;
                results;
            end
        end
    endtask

    task waitIrq(output int c);
        begin
            for (c = 0; c < 400; c++) begin
                @(posedge clk_sys);
                if (mergedIrq === 1'b1) break;
            end
            if (c == 400) begin
                failures++;
                results;
            end
        end
    endtask

    initial begin
        void'($urandom(32'h5f9549d2));
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            xfer(0, 12'(i * 32 + 8), 0);
            check(rdata, 0);
        end
        check({24'h0, timerIrq}, 32'h80);
        check({24'h0, timerEn}, 0);
        xfer(1, 12'h200, $urandom);
        check({31'h0, err}, 1);
        $display("test 1 done");
        ld = 20 + $urandom % 20;
        xfer(1, 12'h028, 0);
        xfer(1, 12'h020, ld);
        xfer(1, 12'h028, 3);
        waitIrq(n);
        check(32'(n >= ld && n <= ld + 6), 1);
        check({31'h0, timerToggle[1]}, 1);
        xfer(0, 12'h024, 0);
        check(32'(rdata <= ld && rdata + 12 >= ld), 1);
        xfer(0, 12'h100, 0);
        check({31'h0, rdata[1]}, 1);
        xfer(0, 12'h02c, 0);
        repeat (2) @(posedge clk_sys);
        check({31'h0, mergedIrq}, 0);
        xfer(1, 12'h028, 0);
        check({31'h0, timerEn[1]}, 0);
        $display("test 2 done");
        xfer(1, 12'h028, 1);
        waitIrq(n);
        xfer(0, 12'h024, 0);
        check(32'(rdata >= 32'hf0 && rdata <= 32'hff), 1);
        xfer(1, 12'h028, 5);
        repeat (ld + 8) @(posedge clk_sys);
        check({31'h0, mergedIrq}, 0);
        xfer(0, 12'h108, 0);
        check({31'h0, rdata[1]}, 1);
        xfer(0, 12'h104, 0);
        xfer(0, 12'h108, 0);
        check({31'h0, rdata[1]}, 0);
        xfer(1, 12'h028, 0);
        $display("test 3 done");
        xfer(1, 12'h000, 3);
        xfer(1, 12'h008, 3);
        waitIrq(n);
        check(32'(n >= 6 && n <= 24), 1);
        xfer(1, 12'h008, 0);
        $display("test 4 done");
        for (int i = 0; i < 8; i++) begin
            ld = $urandom % 8 & 6;
            xfer(1, 12'(i * 32 + 8), ld);
            xfer(0, 12'(i * 32 + 8), 0);
            check(rdata, ld);
            xfer(1, 12'(i * 32 + 8), 0);
        end
        $display("test 5 done");
        results;
    end
endmodule // tb_top
